//--- hdl/fpmna_pkg.sv
// Constants shared by the multiply-low / negative-magnitude slice.
// Assumes a 32-bit core with big-endian instruction bit numbering.
`default_nettype none

package fpmna_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;   // General register width
  localparam int unsigned IDX_W  = 5;    // Register index width
  localparam int unsigned ADDR_W = 8;    // Register bus address width
  localparam int unsigned INT_W  = 2;    // Interrupt event count

  // ----------------------------------------------------------------
  // Instruction encoding (index 0 is the word's last bit)
  // ----------------------------------------------------------------
  localparam logic [5:0] PRIMARY_OP  = 6'h1f;   // Primary opcode 31
  localparam logic [8:0] XO_MUL_LOW  = 9'h0eb;  // Extended opcode 235
  localparam logic [8:0] XO_NEG_MAG  = 9'h1e8;  // Extended opcode 488
  localparam int unsigned POS_PRIMARY_LO = 26;  // Bits 0-5
  localparam int unsigned POS_DEST_LO    = 21;  // Bits 6-10
  localparam int unsigned POS_OVF_CHECK  = 10;  // Bit 21
  localparam int unsigned POS_XO_LO      = 1;   // Bits 22-30
  localparam int unsigned POS_RECORD     = 0;   // Bit 31

  // ----------------------------------------------------------------
  // Fixed exception register and condition field zero layout
  // ----------------------------------------------------------------
  localparam int unsigned FXR_SUMMARY_POS = 31;  // Sticky summary
  localparam int unsigned FXR_WIDE_POS    = 30;  // Result too wide
  localparam int unsigned FXR_WRAP_POS    = 29;  // Unsigned wrap
  localparam int unsigned CR_BELOW_POS    = 3;
  localparam int unsigned CR_ABOVE_POS    = 2;
  localparam int unsigned CR_ZERO_POS     = 1;
  localparam int unsigned CR_SUMMARY_POS  = 0;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FXR        = 8'h00;
  localparam logic [7:0] OFF_CR0        = 8'h04;
  localparam logic [7:0] OFF_INT_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_MASK   = 8'h0c;
  localparam int unsigned INT_WIDE_POS    = 0;   // Overflow event
  localparam int unsigned INT_ILLEGAL_POS = 1;   // Rejected issue
  localparam logic       FLAG_RST  = 1'h0;
  localparam logic [3:0] CR0_RST   = 4'h0;
  localparam logic [1:0] MASK_RST  = 2'h0;
  localparam logic [1:0] STAT_RST  = 2'h0;

  // ----------------------------------------------------------------
  // Operation classes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_MUL_LOW,
    OP_NEG_MAG,
    OP_ILLEGAL
  } fpmna_op_e;

endpackage

`default_nettype wire

//--- hdl/fpmna_if.sv
// Bundle between the slice top and its arithmetic core.
// Assumes both ends sit on the same clock; all signals are combinational.
`default_nettype none

interface fpmna_if;
  // ----------------------------------------------------------------
  // Towards the core
  // ----------------------------------------------------------------
  logic [31:0]          instr;        // Issued instruction word
  logic [31:0]          source_a;     // First operand
  logic [31:0]          source_b;     // Second operand
  logic                 legacy_ok;    // Older variant in force
  logic                 summary_in;   // Current sticky summary flag
  // ----------------------------------------------------------------
  // From the core
  // ----------------------------------------------------------------
  fpmna_pkg::fpmna_op_e op;           // Decoded class
  logic [4:0]           dest_register;
  logic                 ovf_check;    // Overflow-check option
  logic                 record_enable;
  logic [31:0]          result;       // Value for the destination
  logic                 flags_upd;    // Summary/too-wide update
  logic                 summary_out;
  logic                 wide_out;
  logic [3:0]           cr0_new;

  modport top (
    output instr, source_a, source_b, legacy_ok, summary_in,
    input  op, dest_register, ovf_check, record_enable, result,
    input  flags_upd, summary_out, wide_out, cr0_new
  );
  modport core (
    input  instr, source_a, source_b, legacy_ok, summary_in,
    output op, dest_register, ovf_check, record_enable, result,
    output flags_upd, summary_out, wide_out, cr0_new
  );
endinterface

`default_nettype wire

//--- hdl/fpmna_core.sv
// Combinational decode and arithmetic of the slice.
// Assumes the top registers every result it takes from here.
`default_nettype none

module fpmna_core (
  // Bundle towards the top
  fpmna_if.core bus
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [5:0]  primary;       // Primary opcode field
  logic [8:0]  ext_op;        // Extended opcode field
  logic        is_mul;        // Multiply-low encoding
  logic        is_neg;        // Negative-magnitude encoding

  assign primary = bus.instr[fpmna_pkg::POS_PRIMARY_LO +: 6];
  assign ext_op  = bus.instr[fpmna_pkg::POS_XO_LO +: 9];
  assign is_mul  = (primary == fpmna_pkg::PRIMARY_OP) &&
                   (ext_op == fpmna_pkg::XO_MUL_LOW);
  assign is_neg  = (primary == fpmna_pkg::PRIMARY_OP) &&
                   (ext_op == fpmna_pkg::XO_NEG_MAG);
  assign bus.dest_register = bus.instr[fpmna_pkg::POS_DEST_LO +: 5];
  assign bus.ovf_check     = bus.instr[fpmna_pkg::POS_OVF_CHECK];
  assign bus.record_enable = bus.instr[fpmna_pkg::POS_RECORD];

  // Older-variant gate: the newer set has no negative magnitude
  assign bus.op = is_mul ? fpmna_pkg::OP_MUL_LOW :
                  (is_neg && bus.legacy_ok) ? fpmna_pkg::OP_NEG_MAG :
                  fpmna_pkg::OP_ILLEGAL;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic signed [63:0] product;    // Full signed product
  logic               too_wide;   // Product leaves 32 signed bits
  logic [31:0]        neg_mag;    // Negated magnitude

  // Current and legacy mnemonics share this one encoding
  assign product  = $signed(bus.source_a) * $signed(bus.source_b);
  assign too_wide = !((&product[63:31]) || !(|product[63:31]));
  // The most negative input passes unchanged, which is still negative
  assign neg_mag  = bus.source_a[31] ? bus.source_a
                                     : 32'h0000_0000 - bus.source_a;

  always_comb begin
    bus.result      = 32'h0000_0000;
    bus.wide_out    = 1'b0;
    bus.summary_out = bus.summary_in;
    unique case (bus.op)
      fpmna_pkg::OP_MUL_LOW: begin
        bus.result      = product[31:0];
        bus.wide_out    = too_wide;
        bus.summary_out = bus.summary_in | too_wide;
      end
      fpmna_pkg::OP_NEG_MAG: begin
        bus.result      = neg_mag;
        bus.wide_out    = 1'b0;
        bus.summary_out = bus.summary_in;
      end
      fpmna_pkg::OP_ILLEGAL: begin
        bus.result      = 32'h0000_0000;
      end
    endcase
  end

  // Flags move only when the overflow check is asked for
  assign bus.flags_upd = bus.ovf_check &&
                         (bus.op != fpmna_pkg::OP_ILLEGAL);

  // ----------------------------------------------------------------
  // Condition field zero
  // ----------------------------------------------------------------
  // Signed compare of the written value; summary copied after update
  function automatic logic [3:0] cr_field(input logic [31:0] v,
                                          input logic        s);
    logic [3:0] f;
    f = 4'h0;
    f[fpmna_pkg::CR_BELOW_POS]   = v[31];
    f[fpmna_pkg::CR_ABOVE_POS]   = !v[31] && (|v);
    f[fpmna_pkg::CR_ZERO_POS]    = !(|v);
    f[fpmna_pkg::CR_SUMMARY_POS] = s;
    return f;
  endfunction

  assign bus.cr0_new = cr_field(bus.result,
                         bus.flags_upd ? bus.summary_out
                                       : bus.summary_in);

endmodule

`default_nettype wire

//--- hdl/fpmna_top.sv
// Execution slice for multiply-low and negative magnitude.
// Assumes decode hands one instruction per cycle with operands ready,
// and that the writeback port accepts every result without stalling.
//
// Function
// - Multiply writes low 32 product bits
// - Multiply never touches unsigned wrap flag
// - Checked multiply overflow sets summary, too-wide
// - Record updates condition field zero bits
// - Negative magnitude writes minus absolute value
// - Checked negative magnitude clears too-wide only
// - Negative magnitude never touches wrap flag
// - Negative magnitude only on older variant
// - Compare bits use signed result
// - Field summary copies updated sticky flag
`default_nettype none

module fpmna_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Issue from decode
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic [31:0] issue_source_a,
  input  wire logic [31:0] issue_source_b,
  input  wire logic        legacy_arch,
  // Writeback to the register file
  output logic             wb_valid_q,
  output logic [4:0]       wb_dest_register_q,
  output logic [31:0]      wb_data_q,
  // Architected flag state
  output logic             summary_flag_q,
  output logic             result_too_wide_flag_q,
  output logic             unsigned_wrap_flag_q,
  output logic [3:0]       cr0_q,
  // Events
  output logic             illegal_q,
  output logic             irq_q,
  // Register bus
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic [31:0]      reg_rdata_q
);

  // ----------------------------------------------------------------
  // Core hookup
  // ----------------------------------------------------------------
  fpmna_if cbus ();                    // Bundle to the arithmetic

  fpmna_core u_core (
    .bus (cbus.core)
  );

  assign cbus.instr      = issue_instr;
  assign cbus.source_a   = issue_source_a;
  assign cbus.source_b   = issue_source_b;
  assign cbus.legacy_ok  = legacy_arch;
  // Core sees the flag as it stands before this cycle's update
  assign cbus.summary_in = summary_flag_q;

  // ----------------------------------------------------------------
  // Issue qualification
  // ----------------------------------------------------------------
  logic do_exec;        // Accepted instruction this cycle
  logic illegal_ev;     // Rejected instruction this cycle
  logic flag_write;     // Instruction writes summary and too-wide
  logic cr_write;       // Instruction writes condition field zero
  logic wide_ev;        // Checked overflow seen

  assign do_exec    = issue_valid &&
                      (cbus.op != fpmna_pkg::OP_ILLEGAL);
  assign illegal_ev = issue_valid &&
                      (cbus.op == fpmna_pkg::OP_ILLEGAL);
  assign flag_write = do_exec && cbus.flags_upd;
  assign cr_write   = do_exec && cbus.record_enable;
  assign wide_ev    = flag_write && cbus.wide_out;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic wr_fxr;         // Write to exception register
  logic wr_cr0;         // Write to condition field zero
  logic wr_stat;        // Write-one-to-clear status
  logic wr_mask;        // Write to mask

  assign wr_fxr  = reg_we && (reg_addr == fpmna_pkg::OFF_FXR);
  assign wr_cr0  = reg_we && (reg_addr == fpmna_pkg::OFF_CR0);
  assign wr_stat = reg_we && (reg_addr == fpmna_pkg::OFF_INT_STATUS);
  assign wr_mask = reg_we && (reg_addr == fpmna_pkg::OFF_INT_MASK);

  // ----------------------------------------------------------------
  // Writeback stage
  // ----------------------------------------------------------------
  // Single register stage; a rejected issue never reaches the port
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_valid_q         <= 1'b0;
      wb_dest_register_q <= 5'h00;
      wb_data_q          <= 32'h0000_0000;
    end else begin
      wb_valid_q <= do_exec;
      if (do_exec) begin
        wb_dest_register_q <= cbus.dest_register;
        wb_data_q          <= cbus.result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception flags
  // ----------------------------------------------------------------
  logic summary_d;      // Next sticky summary
  logic wide_d;         // Next too-wide flag
  logic wrap_d;         // Next unsigned wrap flag

  // An instruction outranks a software write in the same cycle,
  // so an overflow is never lost to a racing store
  assign summary_d = flag_write ? cbus.summary_out :
                     wr_fxr ? reg_wdata[fpmna_pkg::FXR_SUMMARY_POS] :
                     summary_flag_q;
  assign wide_d    = flag_write ? cbus.wide_out :
                     wr_fxr ? reg_wdata[fpmna_pkg::FXR_WIDE_POS] :
                     result_too_wide_flag_q;
  // Neither operation drives the wrap flag; only software does
  assign wrap_d    = wr_fxr ? reg_wdata[fpmna_pkg::FXR_WRAP_POS]
                            : unsigned_wrap_flag_q;

  // Flag state held here for the whole core
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      summary_flag_q         <= fpmna_pkg::FLAG_RST;
      result_too_wide_flag_q <= fpmna_pkg::FLAG_RST;
      unsigned_wrap_flag_q   <= fpmna_pkg::FLAG_RST;
    end else begin
      summary_flag_q         <= summary_d;
      result_too_wide_flag_q <= wide_d;
      unsigned_wrap_flag_q   <= wrap_d;
    end
  end

  // ----------------------------------------------------------------
  // Condition field zero
  // ----------------------------------------------------------------
  logic [3:0] cr0_d;    // Next field value

  assign cr0_d = cr_write ? cbus.cr0_new :
                 wr_cr0 ? reg_wdata[3:0] :
                 cr0_q;

  // Field register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cr0_q <= fpmna_pkg::CR0_RST;
    end else begin
      cr0_q <= cr0_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [1:0] stat_q;   // Sticky event bits
  logic [1:0] stat_d;
  logic [1:0] stat_set; // Events of this cycle
  logic [1:0] mask_q;   // Enables per event
  logic [1:0] mask_d;

  assign stat_set[fpmna_pkg::INT_WIDE_POS]    = wide_ev;
  assign stat_set[fpmna_pkg::INT_ILLEGAL_POS] = illegal_ev;
  // Set wins over a same-cycle write-one clear
  assign stat_d = (stat_q & ~(wr_stat ? reg_wdata[1:0] : 2'h0))
                  | stat_set;
  assign mask_d = wr_mask ? reg_wdata[1:0] : mask_q;

  // Status, mask and the level interrupt
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stat_q    <= fpmna_pkg::STAT_RST;
      mask_q    <= fpmna_pkg::MASK_RST;
      irq_q     <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      // Built from next values so the line tracks status with no lag
      irq_q     <= |(stat_d & mask_d);
      illegal_q <= illegal_ev;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [31:0] fxr_word;  // Exception register as read
  logic [31:0] rd_word;   // Selected word

  always_comb begin
    fxr_word = 32'h0000_0000;
    fxr_word[fpmna_pkg::FXR_SUMMARY_POS] = summary_flag_q;
    fxr_word[fpmna_pkg::FXR_WIDE_POS]    = result_too_wide_flag_q;
    fxr_word[fpmna_pkg::FXR_WRAP_POS]    = unsigned_wrap_flag_q;
  end

  // Unmapped offsets and reserved bits read as zero
  assign rd_word =
    (reg_addr == fpmna_pkg::OFF_FXR)        ? fxr_word :
    (reg_addr == fpmna_pkg::OFF_CR0)        ? {28'h0000000, cr0_q} :
    (reg_addr == fpmna_pkg::OFF_INT_STATUS) ? {30'h00000000, stat_q} :
    (reg_addr == fpmna_pkg::OFF_INT_MASK)   ? {30'h00000000, mask_q} :
    32'h0000_0000;

  // Data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= reg_re ? rd_word : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

//--- verif/fpmna_top_props.sv
// Port-level checker for the multiply-low / negative-magnitude slice.
// Assumes one clock domain and the bind at the foot of this file.
`default_nettype none

module fpmna_top_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Issue side
  input wire logic        issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [31:0] issue_source_a,
  input wire logic [31:0] issue_source_b,
  input wire logic        legacy_arch,
  // Results and flags
  input wire logic        wb_valid_q,
  input wire logic [31:0] wb_data_q,
  input wire logic        summary_flag_q,
  input wire logic        result_too_wide_flag_q,
  input wire logic        unsigned_wrap_flag_q,
  input wire logic [3:0]  cr0_q,
  input wire logic        illegal_q,
  // Register bus
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_we
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  logic               is_op, is_mul, is_neg, legal, wide, fxr_wr;
  logic signed [63:0] prod;     // Full signed product
  logic [31:0]        mul_lo;   // Expected multiply result
  logic [31:0]        nabs_v;   // Expected negative magnitude
  logic               ovf_opt;  // Overflow-check option bit
  assign is_op  = issue_valid && issue_instr[31:26] == 6'h1f;
  assign is_mul = is_op && issue_instr[9:1] == 9'h0eb;
  assign is_neg = is_op && issue_instr[9:1] == 9'h1e8;
  assign legal  = is_mul || (is_neg && legacy_arch);
  assign prod   = $signed(issue_source_a) * $signed(issue_source_b);
  assign mul_lo = prod[31:0];
  // Too wide when the top 33 bits are not one sign
  assign wide   = !(&prod[63:31] || ~|prod[63:31]);
  assign nabs_v = issue_source_a[31] ? issue_source_a
                                     : 32'h0 - issue_source_a;
  // Software writes to the flag register excuse flag checks
  assign fxr_wr = reg_we && reg_addr == 8'h00;
  assign ovf_opt = issue_instr[10];

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_mul_low;
    is_mul |=> wb_valid_q && wb_data_q == $past(mul_lo);
  endproperty
  a_mul_low: assert property (p_mul_low)
    else $error("multiply result is not the low product word");
  property p_wrap_keep;
    issue_valid && !fxr_wr |=> $stable(unsigned_wrap_flag_q);
  endproperty
  a_wrap_keep: assert property (p_wrap_keep)
    else $error("wrap flag moved on an instruction");
  property p_ovf_set;
    is_mul && ovf_opt && wide |=> summary_flag_q && result_too_wide_flag_q;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("checked overflow did not set both flags");
  property p_cr0;
    legal && issue_instr[0] |=> cr0_q == {wb_data_q[31],
      !wb_data_q[31] && wb_data_q != 0, wb_data_q == 0, summary_flag_q};
  endproperty
  a_cr0: assert property (p_cr0)
    else $error("condition field zero does not match result");
  property p_nabs;
    is_neg && legacy_arch |=> wb_valid_q && wb_data_q == $past(nabs_v)
      && (wb_data_q[31] || wb_data_q == 32'h0);
  endproperty
  a_nabs: assert property (p_nabs)
    else $error("negative magnitude result wrong");
  property p_nabs_ov;
    is_neg && legacy_arch && ovf_opt && !fxr_wr |=>
      !result_too_wide_flag_q && $stable(summary_flag_q);
  endproperty
  a_nabs_ov: assert property (p_nabs_ov)
    else $error("checked negative magnitude flags wrong");
  property p_old_only;
    is_neg && !legacy_arch |=> illegal_q && !wb_valid_q;
  endproperty
  a_old_only: assert property (p_old_only)
    else $error("negative magnitude accepted on newer variant");
  property p_reject;
    issue_valid && !legal && !reg_we |=>
      illegal_q && !wb_valid_q && $stable(cr0_q);
  endproperty
  a_reject: assert property (p_reject)
    else $error("undecoded word was not rejected cleanly");
  property p_keep;
    legal && !ovf_opt && !fxr_wr |=>
      $stable(summary_flag_q) && $stable(result_too_wide_flag_q);
  endproperty
  a_keep: assert property (p_keep)
    else $error("unchecked form changed overflow flags");

  // Main scenarios reached
  c_mul_ovf: cover property (is_mul && ovf_opt && wide);
  c_neg: cover property (is_neg && legacy_arch && ovf_opt);
  c_reject: cover property (issue_valid && !legal);
endmodule

bind fpmna_top fpmna_top_props u_props (
  .ref_clk(ref_clk), .srst(srst), .issue_valid(issue_valid),
  .issue_instr(issue_instr), .issue_source_a(issue_source_a),
  .issue_source_b(issue_source_b), .legacy_arch(legacy_arch),
  .wb_valid_q(wb_valid_q), .wb_data_q(wb_data_q),
  .summary_flag_q(summary_flag_q),
  .result_too_wide_flag_q(result_too_wide_flag_q),
  .unsigned_wrap_flag_q(unsigned_wrap_flag_q), .cr0_q(cr0_q),
  .illegal_q(illegal_q), .reg_addr(reg_addr), .reg_we(reg_we)
);

`default_nettype wire

//--- verif/fpmna_issuer.sv
// Stand-in for decode: hands the slice one instruction per call.
// Assumes send is entered right after a rising edge.
`default_nettype none

module fpmna_issuer (
  // Clock
  input  wire logic   clk,
  // Issue towards the slice
  output logic        valid,
  output logic [31:0] instr,
  output logic [31:0] src_a,
  output logic [31:0] src_b,
  output logic        legacy
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle at time zero
  initial begin
    valid = 1'b0;
    instr = 32'h0;
    src_a = 32'h0;
    src_b = 32'h0;
    legacy = 1'b0;
  end

  // Held until the taking edge; when last is set, valid then drops and word and operands invert so a
  // stale operand never looks like a live one
  task automatic send(input logic [31:0] i, a, b, input logic leg, last);
    valid <= 1'b1;
    instr <= i;
    src_a <= a;
    src_b <= b;
    legacy <= leg;
    @(posedge clk);
    if (last) begin
      valid <= 1'b0;
      instr <= ~i;
      src_a <= ~a;
      src_b <= ~b;
    end
  endtask
endmodule

`default_nettype wire

//--- verif/fpmna_top_bench.sv
// Self-checking bench for the slice top with an integer reference model.
// Assumes the issuer model and the bound checker are compiled alongside.
`default_nettype none

module fpmna_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, srst, iv, leg;      // Clock, reset, issue
  logic [31:0] ii, ia, ib;                  // Issue word, operands
  logic        wbv, sf, wf, cf, ill, irq;   // Design outputs
  logic [4:0]  wbd;
  logic [31:0] wdat, rdat, a, b;
  logic [3:0]  cr0;
  logic [7:0]  reg_addr;                    // Register bus
  logic [31:0] reg_wdata;
  logic        reg_we, reg_re;
  logic [8:0]  xo;
  int          error_cnt, samples_checked, x;
  logic        s_m, ov_m, ca_m, pend, e_ill; // Reference state
  logic [3:0]  cr_m;
  logic [31:0] e_d;
  logic [4:0]  e_rt;
  logic [7:0]  mk_offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};

  fpmna_issuer u_src (.clk(ref_clk), .valid(iv), .instr(ii), .src_a(ia),
    .src_b(ib), .legacy(leg));
  fpmna_top u_dut (.ref_clk(ref_clk), .srst(srst), .issue_valid(iv),
    .issue_instr(ii), .issue_source_a(ia), .issue_source_b(ib),
    .legacy_arch(leg), .wb_valid_q(wbv), .wb_dest_register_q(wbd),
    .wb_data_q(wdat), .summary_flag_q(sf), .result_too_wide_flag_q(wf),
    .unsigned_wrap_flag_q(cf), .cr0_q(cr0), .illegal_q(ill),
    .irq_q(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(rdat));

  // Compare one value and count it
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Register bus cycles
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_we <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    reg_re <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    @(posedge ref_clk);
    chk("rdata", e, rdat);
  endtask
  // Word builder, operand index fields are arbitrary
  function automatic logic [31:0] mk(logic [8:0] o, logic v, logic r,
                                     logic [4:0] t);
    return {6'h1f, t, 10'h0a5, v, o, r};
  endfunction

  // ------------------------------------------------------------
  // Reference model: checks last cycle's result, then steps
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin : model
    logic signed [63:0] p;
    logic [31:0]        r;
    logic               w, ok, mul;
    if (srst) begin
      {s_m, ov_m, ca_m, pend, cr_m} = 8'h00;
    end else begin
      if (pend) begin
        chk("wb_valid", {31'h0, !e_ill}, {31'h0, wbv});
        chk("illegal", {31'h0, e_ill}, {31'h0, ill});
        if (!e_ill) chk("wb_data", e_d, wdat);
        if (!e_ill) chk("dest", {27'h0, e_rt}, {27'h0, wbd});
      end
      chk("flags", {29'h0, s_m, ov_m, ca_m}, {29'h0, sf, wf, cf});
      chk("cr0", {28'h0, cr_m}, {28'h0, cr0});
      pend = iv;
      if (reg_we && reg_addr == 8'h00) {s_m, ov_m, ca_m} = reg_wdata[31:29];
      if (reg_we && reg_addr == 8'h04) cr_m = reg_wdata[3:0];
      if (iv) begin
        p = $signed(ia) * $signed(ib);
        w = !(&p[63:31] || ~|p[63:31]);
        mul = ii[9:1] == 9'h0eb;
        ok = ii[31:26] == 6'h1f && (mul || (ii[9:1] == 9'h1e8 && leg));
        r = mul ? p[31:0] : (ia[31] ? ia : 32'h0 - ia);
        e_ill = !ok;
        e_d = r;
        e_rt = ii[25:21];
        // Checked multiply may set, checked negation only clears
        if (ok && ii[10]) begin
          ov_m = mul & w;
          s_m = s_m | (mul & w);
        end
        if (ok && ii[0]) cr_m = {r[31], !r[31] && r != 0, r == 0, s_m};
      end
    end
  end

  // Clock at 125 MHz
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cut a hang short well past the expected run length
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    results();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {srst, reg_we, reg_re, reg_addr} = 11'h400;
    reg_wdata = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    x = $urandom(12161);
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    // Reset values, then an unmapped place reading zero
    foreach (mk_offs[i]) rd(mk_offs[i], 32'h0);
    wr(8'h00, 32'h2000_0000);
    wr(8'h0c, 32'h1);
    u_src.send(32'h7c64_55d7, 32'h4500, 32'h7fff_ffff, 1'b1, 1'b1);
    @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(8'h08, 32'h1);
    wr(8'h08, 32'h1);
    @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    // Most negative input, newer variant, undecoded word, back to back
    u_src.send(mk(9'h1e8, 1, 1, 5'h6), 32'h8000_0000, 32'h1, 1, 0);
    u_src.send(mk(9'h1e8, 0, 1, 5'h7), 32'h3000, 32'h0, 0, 0);
    u_src.send(32'h0000_01d6, 32'h1, 32'h1, 1'b1, 1'b1);
    @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h08, 32'h2);
    // Random mix, every cycle, either variant
    for (int k = 0; k < 300; k++) begin
      x = $urandom_range(2);
      xo = x == 0 ? 9'h0eb : (x == 1 ? 9'h1e8 : 9'($urandom));
      a = $urandom >> $urandom_range(31);
      b = $urandom >> $urandom_range(31);
      u_src.send(mk(xo, 1'($urandom), 1'($urandom), 5'($urandom)), a, b,
                 1'($urandom), k == 299);
    end
    @(posedge ref_clk);
    rd(8'h00, {s_m, ov_m, ca_m, 29'h0});
    results();
  end
endmodule

`default_nettype wire
